/* bench/mbsp_jtag_model.sv */
`timescale 1ns/100ps
module mbsp_jtag_model (
	input  wire logic clk_in,
	input  wire logic tdo_in,
	output logic      tck_out,
	output logic      tms_out,
	output logic      tdi_out,
	output logic      trst_n_out,
	output logic [3:0] drv_out
);
	// ************************************************************
	// Tester side of the scan port
	// ************************************************************
	// Clock starts low so the first rise is a real one; between steps it rests high
	initial begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b1;
		trst_n_out = 1'b1;
		drv_out = 4'hf;
	end

	// One test clock period: 5 cycles low, 5 high, 10 MHz stays under the cap
	task step(input logic m, input logic d, output logic q);
		@(posedge clk_in);
		tck_out <= 1'b0;
		tms_out <= m;
		tdi_out <= d;
		repeat (5) @(posedge clk_in);
		q = tdo_in;
		tck_out <= 1'b1;
		repeat (4) @(posedge clk_in);
	endtask : step

	// An undriven line shows the opposite level, so only the pull-up can save it
	task reset_line(input logic drive, input logic lvl);
		@(posedge clk_in);
		drv_out[3] <= drive;
		trst_n_out <= drive ? lvl : ~trst_n_out;
	endtask : reset_line

	// Releases or retakes the data line; only the pull-up decides its level then
	task data_line(input logic drive);
		@(posedge clk_in);
		drv_out[2] <= drive;
	endtask : data_line
endmodule : mbsp_jtag_model

/* bench/mbsp_top_assertions.sv */
`timescale 1ns/100ps
module mbsp_top_assertions (
	input wire logic        CORE_CLK_IN,
	input wire logic        RST_IN,
	input wire logic        TCK_IN,
	input wire logic        TRST_N_IN,
	input wire logic [3:0]  TEST_PIN_DRIVEN_IN,
	input wire logic [31:0] PARALLEL_DATA_INPUTS_IN,
	input wire logic        LOOP_ENABLE_N_IN,
	input wire logic        LOAD_PHASE_SELECT_1_IN,
	input wire logic        LOAD_PHASE_SELECT_2_IN,
	input wire logic        CORE_DIVIDED_CLOCK_IN,
	input wire logic        TDO_OUT,
	input wire logic        TDO_OE_OUT,
	input wire logic        DIVIDED_CLOCK_OUT,
	input wire logic [31:0] CORE_PARALLEL_DATA_OUT,
	input wire logic        CORE_LOOP_ENABLE_N_OUT,
	input wire logic        CORE_LOAD_PHASE_SELECT_1_OUT,
	input wire logic        CORE_LOAD_PHASE_SELECT_2_OUT
);
	// ************************************************************
	// Port timing checks
	// ************************************************************
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);

	// Test reset pin driven low
	sequence trst_s;
		!TRST_N_IN && TEST_PIN_DRIVEN_IN[3];
	endsequence

	data_follow_a: assert property (!RST_IN |=>
		CORE_PARALLEL_DATA_OUT == $past(PARALLEL_DATA_INPUTS_IN)) else $error("core data stale");
	ctrl_follow_a: assert property (!RST_IN |=>
		CORE_LOOP_ENABLE_N_OUT == $past(LOOP_ENABLE_N_IN)
		&& CORE_LOAD_PHASE_SELECT_2_OUT == $past(LOAD_PHASE_SELECT_2_IN)
		&& CORE_LOAD_PHASE_SELECT_1_OUT == $past(LOAD_PHASE_SELECT_1_IN))
		else $error("core control stale");
	// Output moves on the edge that first samples the test clock low
	tdo_timing_a: assert property ($changed(TDO_OUT) |->
		$past(TCK_IN, 2) && !$past(TCK_IN)) else $error("data out moved off fall");
	oe_rise_a: assert property ($rose(TDO_OE_OUT) |->
		$past(TCK_IN, 2) && !$past(TCK_IN)) else $error("enable rose off fall");
	oe_fall_a: assert property ($fell(TDO_OE_OUT) |->
		($past(TCK_IN, 2) && !$past(TCK_IN))
		|| (!$past(TRST_N_IN) && $past(TEST_PIN_DRIVEN_IN[3])))
		else $error("enable fell off fall");
	trst_oe_a: assert property (trst_s |=> !TDO_OE_OUT) else $error("enable on in reset");
	// A pin value not taken from the core must come from an update on a fall
	divclk_update_a: assert property ($changed(DIVIDED_CLOCK_OUT) &&
		DIVIDED_CLOCK_OUT != $past(CORE_DIVIDED_CLOCK_IN) |->
		($past(TCK_IN, 3) && !$past(TCK_IN, 2)) || ($past(TCK_IN, 4) && !$past(TCK_IN, 3)))
		else $error("clock pin moved without update");
	reset_clear_a: assert property (disable iff (1'b0) RST_IN |=>
		!TDO_OUT && !TDO_OE_OUT && !DIVIDED_CLOCK_OUT && CORE_PARALLEL_DATA_OUT == 32'h0)
		else $error("outputs not cleared");
endmodule : mbsp_top_assertions

bind mbsp_top mbsp_top_assertions chk_u (
	.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .TCK_IN(TCK_IN), .TRST_N_IN(TRST_N_IN),
	.TEST_PIN_DRIVEN_IN(TEST_PIN_DRIVEN_IN), .PARALLEL_DATA_INPUTS_IN(PARALLEL_DATA_INPUTS_IN),
	.LOOP_ENABLE_N_IN(LOOP_ENABLE_N_IN), .LOAD_PHASE_SELECT_1_IN(LOAD_PHASE_SELECT_1_IN),
	.LOAD_PHASE_SELECT_2_IN(LOAD_PHASE_SELECT_2_IN), .CORE_DIVIDED_CLOCK_IN(CORE_DIVIDED_CLOCK_IN),
	.TDO_OUT(TDO_OUT), .TDO_OE_OUT(TDO_OE_OUT), .DIVIDED_CLOCK_OUT(DIVIDED_CLOCK_OUT),
	.CORE_PARALLEL_DATA_OUT(CORE_PARALLEL_DATA_OUT),
	.CORE_LOOP_ENABLE_N_OUT(CORE_LOOP_ENABLE_N_OUT),
	.CORE_LOAD_PHASE_SELECT_1_OUT(CORE_LOAD_PHASE_SELECT_1_OUT),
	.CORE_LOAD_PHASE_SELECT_2_OUT(CORE_LOAD_PHASE_SELECT_2_OUT));

/* bench/mbsp_top_tb_top.sv */
`timescale 1ns/100ps
module mbsp_top_tb_top import mbsp_pkg::*; ;
	// Arbitrary identity values
	localparam logic [3:0]  VER   = 4'h6;
	localparam logic [15:0] PART  = 16'h1e2d;
	localparam logic [10:0] MAKER = 11'h35b;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        tck, tms, tdi, trst_n, tdo, oe, dclk;
	logic [3:0]  drv;
	logic [31:0] pd = 32'h0;
	logic        lpn = 1'b1, s1 = 1'b0, s2 = 1'b0, divided_clock_out = 1'b0;
	logic [35:0] d, q, p0, p1;
	int          error_cnt = 0;
	int          check_count = 0;

	// ************************************************************
	// Clock, core clock source and instances
	// ************************************************************
	always #5 clk = ~clk;
	always @(posedge clk) divided_clock_out <= 1'($urandom());

	mbsp_top #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) dut_u (
		.CORE_CLK_IN(clk), .RST_IN(rst), .TCK_IN(tck), .TMS_IN(tms), .TDI_IN(tdi),
		.TRST_N_IN(trst_n), .TEST_PIN_DRIVEN_IN(drv), .PARALLEL_DATA_INPUTS_IN(pd),
		.LOOP_ENABLE_N_IN(lpn), .LOAD_PHASE_SELECT_1_IN(s1), .LOAD_PHASE_SELECT_2_IN(s2),
		.CORE_DIVIDED_CLOCK_IN(divided_clock_out), .TDO_OUT(tdo), .TDO_OE_OUT(oe), .DIVIDED_CLOCK_OUT(dclk),
		.CORE_PARALLEL_DATA_OUT(), .CORE_LOOP_ENABLE_N_OUT(),
		.CORE_LOAD_PHASE_SELECT_1_OUT(), .CORE_LOAD_PHASE_SELECT_2_OUT());
	mbsp_jtag_model jtag_u (.clk_in(clk), .tdo_in(tdo), .tck_out(tck), .tms_out(tms),
		.tdi_out(tdi), .trst_n_out(trst_n), .drv_out(drv));

	// Identity with whatever the data-in fed in behind it as the top four bits
	function automatic logic [35:0] id_exp(input logic [3:0] t);
		return {t, VER, PART, MAKER, 1'b1};
	endfunction : id_exp
	function automatic logic [35:0] rnd();
		return 36'({$urandom(), $urandom()});
	endfunction : rnd

	task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Data-in is noise outside shifting; the port must ignore it
	task automatic nx(input logic m);
		logic b;
		jtag_u.step(m, 1'($urandom()), b);
	endtask : nx
	// From idle through capture, shift of n bits LSB first, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [35:0] i,
		output logic [35:0] o);
		logic b;
		o = 36'h0;
		nx(1'b1);
		if (ir) nx(1'b1);
		nx(1'b0);
		nx(1'b0);
		for (int k = 0; k < n; k++) begin
			jtag_u.step(k == n - 1, i[k], b);
			o[k] = b;
			chk("enable while shifting", 36'h1, 36'(oe));
		end
		nx(1'b1);
		chk("enable after shift", 36'h0, 36'(oe));
		nx(1'b0);
	endtask : scan
	task automatic ir_load(input logic [1:0] c);
		logic [35:0] o;
		scan(1'b1, 2, 36'(c), o);
		chk("ir capture", 36'h1, o);
	endtask : ir_load
	task automatic follow();
		logic v;
		@(negedge clk);
		v = divided_clock_out;
		@(negedge clk);
		chk("clock pin follows core", 36'(v), 36'(dclk));
	endtask : follow

	task results();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	// Whole run is near 4800 cycles; over twelve times that means a hang
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		results();
	end

	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		void'($urandom(85));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		nx(1'b0);
		scan(1'b0, 32, 36'h0, q);
		chk("idcode at reset", id_exp(4'h0), q);
		ir_load(MBSP_INS_BYPASS);
		d = rnd();
		scan(1'b0, 36, d, q);
		chk("bypass", {d[34:0], 1'b0}, q);
		ir_load(MBSP_INS_IDCODE);
		d = rnd();
		scan(1'b0, 36, d, q);
		chk("idcode length", id_exp(d[3:0]), q);
		ir_load(MBSP_INS_PRELOAD);
		p1 = rnd();
		scan(1'b0, 36, p1, q);
		p0 = rnd();
		scan(1'b0, 36, p0, q);
		chk("preload keeps scan", p1, q);
		follow();
		ir_load(MBSP_INS_EXTEST);
		// The second preload left its bit 35 in the update stage
		p1 = p0;
		chk("extest drive", 36'(p1[35]), 36'(dclk));
		for (int r = 0; r < 4; r++) begin
			@(posedge clk);
			pd <= $urandom();
			{lpn, s1, s2} <= 3'($urandom());
			p0 = p1;
			p1 = rnd();
			scan(1'b0, 36, p1, q);
			chk("extest capture", {p0[35], lpn, s2, s1, pd}, q);
			chk("extest drive", 36'(p1[35]), 36'(dclk));
		end
		jtag_u.reset_line(1'b0, 1'b0);
		repeat (8) @(posedge clk);
		chk("undriven reset ignored", 36'(p1[35]), 36'(dclk));
		jtag_u.reset_line(1'b1, 1'b0);
		repeat (4) @(posedge clk);
		jtag_u.reset_line(1'b1, 1'b1);
		follow();
		nx(1'b0);
		scan(1'b0, 32, 36'h0, q);
		chk("idcode after test reset", id_exp(4'h0), q);
		jtag_u.data_line(1'b0);
		scan(1'b0, 36, 36'h0, q);
		chk("undriven data reads high", id_exp(4'hf), q);
		results();
	end
endmodule : mbsp_top_tb_top

/* common/mbsp_pkg.sv */
package mbsp_pkg;

	// ************************************************************
	// Scan structure sizes
	// ************************************************************
	localparam int          MBSP_IR_W       = 2;
	localparam int          MBSP_ID_W       = 32;
	localparam int          MBSP_BSR_W      = 36;
	localparam int          MBSP_DATA_W     = 32;

	// ************************************************************
	// Instruction codes and reset values
	// ************************************************************
	localparam logic [1:0]  MBSP_INS_EXTEST  = 2'h0;
	localparam logic [1:0]  MBSP_INS_PRELOAD = 2'h1;
	localparam logic [1:0]  MBSP_INS_IDCODE  = 2'h2;
	localparam logic [1:0]  MBSP_INS_BYPASS  = 2'h3;
	localparam logic [1:0]  MBSP_IR_CAPTURE  = 2'h1;
	localparam logic [1:0]  MBSP_IR_RESET    = MBSP_INS_IDCODE;
	localparam logic [35:0] MBSP_BSR_RESET   = 36'h0;

	// ************************************************************
	// Identification field layout
	// ************************************************************
	localparam int          MBSP_ID_VER_LSB  = 28;
	localparam int          MBSP_ID_PART_LSB = 12;
	localparam int          MBSP_ID_MFR_LSB  = 1;
	localparam logic        MBSP_ID_MARKER   = 1'b1;

	// ************************************************************
	// Boundary register positions
	// ************************************************************
	localparam int          MBSP_POS_DIVCLK  = 35;
	localparam int          MBSP_POS_LOOPN   = 34;
	localparam int          MBSP_POS_SEL2    = 33;
	localparam int          MBSP_POS_SEL1    = 32;
	localparam int          MBSP_POS_DATA    = 0;

	// ************************************************************
	// Test clock limits
	// ************************************************************
	localparam int          MBSP_CORE_MHZ    = 100;
	localparam int          MBSP_TCK_MAX_MHZ = 12;
	localparam int          MBSP_TCK_MIN_CYC = MBSP_CORE_MHZ / MBSP_TCK_MAX_MHZ;

	// ************************************************************
	// Controller states
	// ************************************************************
	typedef enum logic [15:0] {
		MBSP_TLR    = 16'h0001,
		MBSP_RTI    = 16'h0002,
		MBSP_SEL_DR = 16'h0004,
		MBSP_CAP_DR = 16'h0008,
		MBSP_SH_DR  = 16'h0010,
		MBSP_EX1_DR = 16'h0020,
		MBSP_PAU_DR = 16'h0040,
		MBSP_EX2_DR = 16'h0080,
		MBSP_UPD_DR = 16'h0100,
		MBSP_SEL_IR = 16'h0200,
		MBSP_CAP_IR = 16'h0400,
		MBSP_SH_IR  = 16'h0800,
		MBSP_EX1_IR = 16'h1000,
		MBSP_PAU_IR = 16'h2000,
		MBSP_EX2_IR = 16'h4000,
		MBSP_UPD_IR = 16'h8000
	} mbsp_tap_state_e;

endpackage : mbsp_pkg

/* common/mbsp_tap_if.sv */
`timescale 1ns/100ps
interface mbsp_tap_if import mbsp_pkg::*; ();
	logic            tck_rise;
	logic            tms;
	logic            tap_reset;
	mbsp_tap_state_e state;

	modport fsm (input tck_rise, input tms, input tap_reset, output state);
	modport user (output tck_rise, output tms, output tap_reset, input state);
endinterface : mbsp_tap_if

/* verilog/mbsp_tap_fsm.sv */
`timescale 1ns/100ps
module mbsp_tap_fsm import mbsp_pkg::*; (
	input  wire logic clk_in,
	input  wire logic rst_in,
	mbsp_tap_if.fsm   tap
);

	mbsp_tap_state_e state;
	mbsp_tap_state_e next_state;

	// ************************************************************
	// Sixteen-state controller walk on each test clock rise
	// ************************************************************
	function automatic mbsp_tap_state_e tap_step(input mbsp_tap_state_e s, input logic m);
		case (s)
			MBSP_TLR:    tap_step = m ? MBSP_TLR    : MBSP_RTI;
			MBSP_RTI:    tap_step = m ? MBSP_SEL_DR : MBSP_RTI;
			MBSP_SEL_DR: tap_step = m ? MBSP_SEL_IR : MBSP_CAP_DR;
			MBSP_CAP_DR: tap_step = m ? MBSP_EX1_DR : MBSP_SH_DR;
			MBSP_SH_DR:  tap_step = m ? MBSP_EX1_DR : MBSP_SH_DR;
			MBSP_EX1_DR: tap_step = m ? MBSP_UPD_DR : MBSP_PAU_DR;
			MBSP_PAU_DR: tap_step = m ? MBSP_EX2_DR : MBSP_PAU_DR;
			MBSP_EX2_DR: tap_step = m ? MBSP_UPD_DR : MBSP_SH_DR;
			MBSP_UPD_DR: tap_step = m ? MBSP_SEL_DR : MBSP_RTI;
			MBSP_SEL_IR: tap_step = m ? MBSP_TLR    : MBSP_CAP_IR;
			MBSP_CAP_IR: tap_step = m ? MBSP_EX1_IR : MBSP_SH_IR;
			MBSP_SH_IR:  tap_step = m ? MBSP_EX1_IR : MBSP_SH_IR;
			MBSP_EX1_IR: tap_step = m ? MBSP_UPD_IR : MBSP_PAU_IR;
			MBSP_PAU_IR: tap_step = m ? MBSP_EX2_IR : MBSP_PAU_IR;
			MBSP_EX2_IR: tap_step = m ? MBSP_UPD_IR : MBSP_SH_IR;
			MBSP_UPD_IR: tap_step = m ? MBSP_SEL_DR : MBSP_RTI;
			default:     tap_step = MBSP_TLR;
		endcase
	endfunction : tap_step

	// Test reset forces the idle reset state at once
	always_comb begin
		next_state = state;
		if (tap.tap_reset) begin
			next_state = MBSP_TLR;
		end else if (tap.tck_rise) begin
			next_state = tap_step(state, tap.tms);
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state <= MBSP_TLR;
		end else begin
			state <= next_state;
		end
	end

	assign tap.state = state;

endmodule : mbsp_tap_fsm

/* verilog/mbsp_top.sv */
`timescale 1ns/100ps
module mbsp_top import mbsp_pkg::*; #(
	parameter logic [3:0]  ID_VERSION = 4'h3,    // Arbitrary value
	parameter logic [15:0] ID_PART    = 16'h5a3c, // Arbitrary value
	parameter logic [10:0] ID_MAKER   = 11'h2d4  // Arbitrary value
) (
	input  wire logic        CORE_CLK_IN,
	input  wire logic        RST_IN,
	input  wire logic        TCK_IN,
	input  wire logic        TMS_IN,
	input  wire logic        TDI_IN,
	input  wire logic        TRST_N_IN,
	input  wire logic [3:0]  TEST_PIN_DRIVEN_IN,
	input  wire logic [31:0] PARALLEL_DATA_INPUTS_IN,
	input  wire logic        LOOP_ENABLE_N_IN,
	input  wire logic        LOAD_PHASE_SELECT_1_IN,
	input  wire logic        LOAD_PHASE_SELECT_2_IN,
	input  wire logic        CORE_DIVIDED_CLOCK_IN,
	output logic             TDO_OUT,
	output logic             TDO_OE_OUT,
	output logic             DIVIDED_CLOCK_OUT,
	output logic [31:0]      CORE_PARALLEL_DATA_OUT,
	output logic             CORE_LOOP_ENABLE_N_OUT,
	output logic             CORE_LOAD_PHASE_SELECT_1_OUT,
	output logic             CORE_LOAD_PHASE_SELECT_2_OUT
);

	// ************************************************************
	// Pin conditioning
	// ************************************************************
	logic tck;
	logic tms;
	logic tdi;
	logic trst_n;

	// Pad pull-ups: a pin reported undriven reads high
	assign tck    = TEST_PIN_DRIVEN_IN[0] ? TCK_IN    : 1'b1;
	assign tms    = TEST_PIN_DRIVEN_IN[1] ? TMS_IN    : 1'b1;
	assign tdi    = TEST_PIN_DRIVEN_IN[2] ? TDI_IN    : 1'b1;
	assign trst_n = TEST_PIN_DRIVEN_IN[3] ? TRST_N_IN : 1'b1;

	// ************************************************************
	// Test clock edge detection
	// ************************************************************
	// The test clock is sampled by the core clock; this works only while each
	// test clock phase spans several core cycles, which the speed cap ensures.
	logic tck_q;
	logic next_tck_q;
	logic tck_rise;
	logic tck_fall;

	// One-cycle pulses; rise and fall can never both be high
	assign tck_rise = tck & ~tck_q;
	assign tck_fall = ~tck & tck_q;

	// Last sampled test clock level
	always_comb begin
		next_tck_q = tck;
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			tck_q <= 1'b1;
		end else begin
			tck_q <= next_tck_q;
		end
	end

	// ************************************************************
	// Controller
	// ************************************************************
	mbsp_tap_if tap ();

	// Test reset pin sends the controller straight to its reset state
	assign tap.tck_rise  = tck_rise;
	assign tap.tms       = tms;
	assign tap.tap_reset = ~trst_n;

	mbsp_tap_fsm u_fsm (
		.clk_in (CORE_CLK_IN),
		.rst_in (RST_IN),
		.tap    (tap)
	);

	mbsp_tap_state_e st;
	assign st = tap.state;

	// ************************************************************
	// Scan registers
	// ************************************************************
	// Instruction, bypass cell, shared scan chain and update stage
	logic [1:0]  ir;
	logic [1:0]  next_ir;
	logic [1:0]  ir_sh;
	logic [1:0]  next_ir_sh;
	logic        byp;
	logic        next_byp;
	logic [35:0] scan;
	logic [35:0] next_scan;
	logic [35:0] upd;
	logic [35:0] next_upd;
	logic        tdo;
	logic        next_tdo;
	logic        tdo_oe;
	logic        next_tdo_oe;
	logic [31:0] id_value;
	logic [35:0] pin_levels;
	logic        sel_bsr;

	// Identity word, marker bit in the lowest place
	assign id_value = {ID_VERSION, ID_PART, ID_MAKER, MBSP_ID_MARKER};

	// Levels seen at the low-speed pins, in boundary order
	assign pin_levels = {DIVIDED_CLOCK_OUT, LOOP_ENABLE_N_IN,
		LOAD_PHASE_SELECT_2_IN, LOAD_PHASE_SELECT_1_IN,
		PARALLEL_DATA_INPUTS_IN};

	// ************************************************************
	// Instruction decode
	// ************************************************************
	// One compare shared by every place that asks which path is selected
	function automatic logic ins_is(input logic [1:0] cur, input logic [1:0] code);
		ins_is = (cur == code);
	endfunction : ins_is

	logic ins_extest;
	logic ins_preload;
	logic ins_idcode;
	logic ins_bypass;

	// Held until the next update, so a decode never changes in mid-shift
	assign ins_extest  = ins_is(ir, MBSP_INS_EXTEST);
	assign ins_preload = ins_is(ir, MBSP_INS_PRELOAD);
	assign ins_idcode  = ins_is(ir, MBSP_INS_IDCODE);
	assign ins_bypass  = ins_is(ir, MBSP_INS_BYPASS);

	// Boundary register is in the path for EXTEST and PRELOAD
	assign sel_bsr = ins_extest || ins_preload;

	// Shift one place toward bit zero, entering at the top of the active length
	function automatic logic [35:0] scan_shift(input logic [35:0] v, input logic d,
		input logic full);
		logic [35:0] r;
		r = v >> 1;
		if (full) begin
			r[MBSP_BSR_W-1] = d;
		end else begin
			r[MBSP_ID_W-1] = d;
			// Top four cells stay zero while the identity is in the path
			r[MBSP_BSR_W-1:MBSP_ID_W] = 4'h0;
		end
		scan_shift = r;
	endfunction : scan_shift

	// Capture, shift and update of instruction and data paths
	always_comb begin
		next_ir     = ir;
		next_ir_sh  = ir_sh;
		next_byp    = byp;
		next_scan   = scan;
		next_upd    = upd;
		next_tdo    = tdo;
		next_tdo_oe = tdo_oe;
		// Reset state reloads the default instruction
		if (st == MBSP_TLR) begin
			next_ir = MBSP_IR_RESET;
		end
		// Capture and shift happen on the test clock rise
		if (tck_rise) begin
			case (st)
				MBSP_CAP_IR: begin
					next_ir_sh = MBSP_IR_CAPTURE;
				end
				MBSP_SH_IR: begin
					next_ir_sh = {tdi, ir_sh[1]};
				end
				MBSP_CAP_DR: begin
					// Bypass cell captures zero
					next_byp = 1'b0;
					if (ins_extest) begin
						next_scan = pin_levels;
					end else if (ins_idcode) begin
						next_scan = {4'h0, id_value};
					end
					// PRELOAD keeps its contents: there is no sample capture
				end
				MBSP_SH_DR: begin
					if (ins_bypass) begin
						next_byp = tdi;
					end else begin
						next_scan = scan_shift(scan, tdi, sel_bsr);
					end
				end
				default: begin
				end
			endcase
		end
		if (tck_fall) begin
			// Test data out changes on the falling test clock edge
			case (st)
				MBSP_SH_IR: begin
					next_tdo    = ir_sh[0];
					next_tdo_oe = 1'b1;
				end
				MBSP_SH_DR: begin
					next_tdo    = ins_bypass ? byp : scan[0];
					next_tdo_oe = 1'b1;
				end
				MBSP_UPD_IR: begin
					// New instruction takes effect on this fall, between shifts
					next_ir     = ir_sh;
					next_tdo_oe = 1'b0;
				end
				MBSP_UPD_DR: begin
					// Update stage keeps its value when another path is selected
					if (sel_bsr) begin
						next_upd = scan;
					end
					next_tdo_oe = 1'b0;
				end
				default: begin
					next_tdo_oe = 1'b0;
				end
			endcase
		end
		// Test reset wins over an instruction update that falls in the same cycle
		if (~trst_n) begin
			next_ir     = MBSP_IR_RESET;
			next_tdo_oe = 1'b0;
		end
	end

	// Registers only; the process above works out every next value
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			ir     <= MBSP_IR_RESET;
			ir_sh  <= MBSP_IR_CAPTURE;
			byp    <= 1'b0;
			scan   <= MBSP_BSR_RESET;
			upd    <= MBSP_BSR_RESET;
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			ir     <= next_ir;
			ir_sh  <= next_ir_sh;
			byp    <= next_byp;
			scan   <= next_scan;
			upd    <= next_upd;
			tdo    <= next_tdo;
			tdo_oe <= next_tdo_oe;
		end
	end

	// Enable is low outside shifting so a shared test data line stays free
	assign TDO_OUT    = tdo;
	assign TDO_OE_OUT = tdo_oe;

	// ************************************************************
	// Pin and core paths
	// ************************************************************
	// Registering the clock output adds one core cycle of delay; it also keeps
	// the EXTEST switchover glitch-free.
	logic        divclk;
	logic        next_divclk;
	logic [35:0] core_in;
	logic [35:0] next_core_in;

	always_comb begin
		next_divclk  = ins_extest ? upd[MBSP_POS_DIVCLK]
			: CORE_DIVIDED_CLOCK_IN;
		next_core_in = pin_levels; // Inputs pass to the core unchanged
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			divclk  <= 1'b0;
			core_in <= MBSP_BSR_RESET;
		end else begin
			divclk  <= next_divclk;
			core_in <= next_core_in;
		end
	end

	// Core side sees the pins one cycle late whatever the instruction;
	// input cells only observe, so EXTEST cannot fence the core off its pins
	assign DIVIDED_CLOCK_OUT            = divclk;
	assign CORE_PARALLEL_DATA_OUT       = core_in[MBSP_DATA_W-1:MBSP_POS_DATA];
	assign CORE_LOOP_ENABLE_N_OUT       = core_in[MBSP_POS_LOOPN];
	assign CORE_LOAD_PHASE_SELECT_1_OUT = core_in[MBSP_POS_SEL1];
	assign CORE_LOAD_PHASE_SELECT_2_OUT = core_in[MBSP_POS_SEL2];

endmodule : mbsp_top
